// [omcs_control.sv]
// control, status and two-wire management logic of the optical module
`timescale 1ns/10ps
`default_nettype none

`include "omcs_map.svh"

module omcs_control #(
    parameter int unsigned T_SERIAL_CYC   = `OMCS_T_SERIAL_CYC,
    parameter int unsigned T_DATA_CYC     = `OMCS_T_DATA_CYC,
    parameter int unsigned T_WR_SHORT_CYC = `OMCS_T_WR_SHORT_CYC,
    parameter int unsigned T_WR_LONG_CYC  = `OMCS_T_WR_LONG_CYC
) (
    // clock and reset
    input  wire logic CLOCK,
    input  wire logic RST_N,
    // host pins
    input  wire logic TX_DISABLE,
    output logic      TX_FAULT_O,
    output logic      TX_FAULT_OE,
    output logic      RX_SIGNAL_LOST_O,
    output logic      RX_SIGNAL_LOST_OE,
    // two-wire management bus
    input  wire logic SCL,
    input  wire logic SDA_I,
    output logic      SDA_O,
    output logic      SDA_OE,
    // optics side
    input  wire logic LASER_FAULT,
    input  wire logic RX_SIGNAL_OK,
    output logic      LASER_ENABLE
);

    // ------------------------------------------------------------------------
    // parameters and checks
    // ------------------------------------------------------------------------
    localparam int         CNT_W    = 25;
    localparam logic [7:0] HOLD_CYC = 8'(`OMCS_T_RESET_CYC);

    if (T_SERIAL_CYC < 1 || T_DATA_CYC < 1 || T_WR_SHORT_CYC < 1 ||
        T_WR_LONG_CYC < T_WR_SHORT_CYC || T_DATA_CYC >= (1 << CNT_W) ||
        T_SERIAL_CYC >= (1 << CNT_W) || T_WR_LONG_CYC >= (1 << CNT_W)) begin : g_bad_counts
        $error("omcs_control timing counts out of range");
    end

    if (`OMCS_T_RESET_CYC < 1 || `OMCS_T_RESET_CYC > 255) begin : g_bad_hold
        $error("omcs_control disable hold count does not fit");
    end

    // ------------------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------------------
    omcs_pkg::omcs_pins_type pins_raw;
    omcs_pkg::omcs_pins_type pins_s;

    assign pins_raw = '{scl: SCL, sda: SDA_I, tx_dis: TX_DISABLE,
                        laser_fault: LASER_FAULT, rx_ok: RX_SIGNAL_OK};

    // disable resets high so the laser never blinks on during reset release
    omcs_sync #(
        .WIDTH     ($bits(omcs_pkg::omcs_pins_type)),
        .RESET_VAL (5'h1c)
    ) u_sync (
        .clk      (CLOCK),
        .rst_n    (RST_N),
        .async_in (pins_raw),
        .sync_out (pins_s)
    );

    // ------------------------------------------------------------------------
    // power-on and write-busy timers
    // ------------------------------------------------------------------------
    logic             bus_wait;
    logic             data_wait;
    logic             wr_busy;
    logic             wr_launch;
    logic [CNT_W-1:0] wr_load_value;

    omcs_timer #(
        .WIDTH      (CNT_W),
        .RESET_LOAD (CNT_W'(T_SERIAL_CYC))
    ) u_bus_ready (
        .clk        (CLOCK),
        .rst_n      (RST_N),
        .load       (1'b0),
        .load_value ('0),
        .running    (bus_wait)
    );

    omcs_timer #(
        .WIDTH      (CNT_W),
        .RESET_LOAD (CNT_W'(T_DATA_CYC))
    ) u_data_ready (
        .clk        (CLOCK),
        .rst_n      (RST_N),
        .load       (1'b0),
        .load_value ('0),
        .running    (data_wait)
    );

    omcs_timer #(
        .WIDTH      (CNT_W),
        .RESET_LOAD ('0)
    ) u_write_busy (
        .clk        (CLOCK),
        .rst_n      (RST_N),
        .load       (wr_launch),
        .load_value (wr_load_value),
        .running    (wr_busy)
    );

    // ------------------------------------------------------------------------
    // laser, fault and loss-of-signal pins
    // ------------------------------------------------------------------------
    logic       tx_dis_prev_q;
    logic       tx_dis_prev_d;
    logic [7:0] hold_q;
    logic [7:0] hold_d;
    logic       fault_q;
    logic       fault_d;
    logic       laser_on_q;
    logic       laser_on_d;
    logic       los_q;
    logic       los_d;
    logic       fault_oe_q;
    logic       fault_oe_d;
    logic       los_oe_q;
    logic       los_oe_d;
    logic       soft_dis_q;
    logic       soft_dis_d;
    logic       fault_clear;

    always_comb begin
        tx_dis_prev_d = pins_s.tx_dis;
        hold_d        = 8'h00;
        if (pins_s.tx_dis) begin
            hold_d = (hold_q == HOLD_CYC) ? hold_q : hold_q + 8'h01;
        end
        fault_clear = tx_dis_prev_q && !pins_s.tx_dis && (hold_q == HOLD_CYC);
        fault_d     = fault_q;
        if (fault_clear) begin
            fault_d = 1'b0;
        end
        // a fault in the clearing cycle still wins
        if (pins_s.laser_fault) begin
            fault_d = 1'b1;
        end
        // pin and fault paths act next cycle, the soft bit only after a stop
        laser_on_d = !(pins_s.tx_dis || fault_d || soft_dis_q);
        fault_oe_d = !fault_d;
        los_d      = !pins_s.rx_ok;
        los_oe_d   = pins_s.rx_ok;
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            tx_dis_prev_q <= 1'b1;
            hold_q        <= 8'h00;
            fault_q       <= 1'b0;
            laser_on_q    <= 1'b0;
            los_q         <= 1'b1;
            fault_oe_q    <= 1'b1;
            los_oe_q      <= 1'b0;
        end else begin
            tx_dis_prev_q <= tx_dis_prev_d;
            hold_q        <= hold_d;
            fault_q       <= fault_d;
            laser_on_q    <= laser_on_d;
            los_q         <= los_d;
            fault_oe_q    <= fault_oe_d;
            los_oe_q      <= los_oe_d;
        end
    end

    // ------------------------------------------------------------------------
    // status byte and read data
    // ------------------------------------------------------------------------
    omcs_pkg::omcs_status_type status;

    always_comb begin
        status            = '0;
        status.tx_dis_pin = pins_s.tx_dis;
        status.soft_dis   = soft_dis_q;
        status.fault      = fault_q;
        status.sig_lost   = los_q;
        status.not_ready  = data_wait;
    end

    // unmapped bytes of either space read as zero
    function automatic logic [7:0] rd_byte(input logic diag, input logic [7:0] ptr,
                                           input omcs_pkg::omcs_status_type st);
        rd_byte = (diag && ptr == `OMCS_CSB_OFFSET) ? st : 8'h00;
    endfunction : rd_byte

    function automatic logic addr_hit(input logic [6:0] addr);
        addr_hit = (addr == `OMCS_ID_SPACE) || (addr == `OMCS_DIAG_SPACE);
    endfunction : addr_hit

    // ------------------------------------------------------------------------
    // two-wire target
    // ------------------------------------------------------------------------
    omcs_pkg::omcs_state_type state_q;
    omcs_pkg::omcs_state_type state_d;
    logic       scl_prev_q;
    logic       scl_prev_d;
    logic       sda_prev_q;
    logic       sda_prev_d;
    logic [7:0] shift_q;
    logic [7:0] shift_d;
    logic [2:0] bit_q;
    logic [2:0] bit_d;
    logic [7:0] ptr_q;
    logic [7:0] ptr_d;
    logic       first_q;
    logic       first_d;
    logic       read_q;
    logic       read_d;
    logic       diag_q;
    logic       diag_d;
    logic       ack_drv_q;
    logic       ack_drv_d;
    logic       sda_oe_q;
    logic       sda_oe_d;
    logic [3:0] wr_cnt_q;
    logic [3:0] wr_cnt_d;
    logic       wr_pend_q;
    logic       wr_pend_d;
    logic [7:0] wr_val_q;
    logic [7:0] wr_val_d;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_seen;
    logic       stop_seen;
    logic [7:0] rd_now;

    always_comb begin
        scl_rise   = pins_s.scl && !scl_prev_q;
        scl_fall   = !pins_s.scl && scl_prev_q;
        start_seen = pins_s.scl && scl_prev_q && sda_prev_q && !pins_s.sda;
        stop_seen  = pins_s.scl && scl_prev_q && !sda_prev_q && pins_s.sda;
        rd_now     = rd_byte(diag_q, ptr_q, status);
        scl_prev_d = pins_s.scl;
        sda_prev_d = pins_s.sda;
        state_d    = state_q;
        shift_d    = shift_q;
        bit_d      = bit_q;
        ptr_d      = ptr_q;
        first_d    = first_q;
        read_d     = read_q;
        diag_d     = diag_q;
        ack_drv_d  = ack_drv_q;
        sda_oe_d   = sda_oe_q;
        wr_cnt_d   = wr_cnt_q;
        wr_pend_d  = wr_pend_q;
        wr_val_d   = wr_val_q;
        soft_dis_d = soft_dis_q;
        wr_launch  = 1'b0;
        // more than four bytes needs the long busy time
        wr_load_value = (wr_cnt_q > `OMCS_WR_SHORT_BYTES) ? CNT_W'(T_WR_LONG_CYC)
                                                          : CNT_W'(T_WR_SHORT_CYC);
        if (stop_seen) begin
            state_d   = omcs_pkg::ST_IDLE;
            sda_oe_d  = 1'b0;
            wr_launch = (wr_cnt_q != 4'h0);
            if (wr_pend_q) begin
                soft_dis_d = wr_val_q[`OMCS_SOFT_DIS_BIT];
            end
            wr_pend_d = 1'b0;
            wr_cnt_d  = 4'h0;
        end else if (start_seen) begin
            state_d  = omcs_pkg::ST_ADDR;
            bit_d    = 3'h0;
            sda_oe_d = 1'b0;
            first_d  = 1'b1;
        end else begin
            unique case (state_q)
                omcs_pkg::ST_IDLE: begin
                end
                omcs_pkg::ST_ADDR: begin
                    if (scl_rise) begin
                        shift_d = {shift_q[6:0], pins_s.sda};
                        bit_d   = bit_q + 3'h1;
                        if (bit_q == 3'h7) begin
                            // silent until ready, and while a write completes
                            if (!bus_wait && !wr_busy && addr_hit(shift_d[7:1])) begin
                                state_d   = omcs_pkg::ST_ACK;
                                ack_drv_d = 1'b0;
                                read_d    = shift_d[0];
                                diag_d    = (shift_d[7:1] == `OMCS_DIAG_SPACE);
                            end else begin
                                state_d = omcs_pkg::ST_IDLE;
                            end
                        end
                    end
                end
                omcs_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        if (!ack_drv_q) begin
                            sda_oe_d  = 1'b1;
                            ack_drv_d = 1'b1;
                        end else begin
                            ack_drv_d = 1'b0;
                            bit_d     = 3'h0;
                            if (read_q) begin
                                state_d  = omcs_pkg::ST_RBYTE;
                                shift_d  = rd_now;
                                sda_oe_d = !rd_now[7];
                            end else begin
                                state_d  = omcs_pkg::ST_WBYTE;
                                sda_oe_d = 1'b0;
                            end
                        end
                    end
                end
                omcs_pkg::ST_WBYTE: begin
                    if (scl_rise) begin
                        shift_d = {shift_q[6:0], pins_s.sda};
                        bit_d   = bit_q + 3'h1;
                        if (bit_q == 3'h7) begin
                            state_d   = omcs_pkg::ST_ACK;
                            ack_drv_d = 1'b0;
                            if (first_q) begin
                                ptr_d   = shift_d;
                                first_d = 1'b0;
                            end else if (wr_cnt_q == `OMCS_WR_MAX_BYTES) begin
                                // a ninth data byte is not acknowledged
                                state_d = omcs_pkg::ST_IDLE;
                            end else begin
                                if (diag_q && ptr_q == `OMCS_CSB_OFFSET) begin
                                    wr_val_d  = shift_d;
                                    wr_pend_d = 1'b1;
                                end
                                ptr_d    = ptr_q + 8'h01;
                                wr_cnt_d = wr_cnt_q + 4'h1;
                            end
                        end
                    end
                end
                omcs_pkg::ST_RBYTE: begin
                    if (scl_fall) begin
                        if (bit_q == 3'h7) begin
                            sda_oe_d = 1'b0;
                            state_d  = omcs_pkg::ST_RACK;
                            ptr_d    = ptr_q + 8'h01;
                        end else begin
                            shift_d  = {shift_q[6:0], 1'b0};
                            sda_oe_d = !shift_q[6];
                            bit_d    = bit_q + 3'h1;
                        end
                    end
                end
                omcs_pkg::ST_RACK: begin
                    if (scl_rise) begin
                        if (!pins_s.sda) begin
                            state_d   = omcs_pkg::ST_ACK;
                            ack_drv_d = 1'b1;
                        end else begin
                            state_d = omcs_pkg::ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            state_q    <= omcs_pkg::ST_IDLE;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
            shift_q    <= 8'h00;
            bit_q      <= 3'h0;
            ptr_q      <= 8'h00;
            first_q    <= 1'b1;
            read_q     <= 1'b0;
            diag_q     <= 1'b0;
            ack_drv_q  <= 1'b0;
            sda_oe_q   <= 1'b0;
            wr_cnt_q   <= 4'h0;
            wr_pend_q  <= 1'b0;
            wr_val_q   <= 8'h00;
            soft_dis_q <= `OMCS_SOFT_DIS_RESET;
        end else begin
            state_q    <= state_d;
            scl_prev_q <= scl_prev_d;
            sda_prev_q <= sda_prev_d;
            shift_q    <= shift_d;
            bit_q      <= bit_d;
            ptr_q      <= ptr_d;
            first_q    <= first_d;
            read_q     <= read_d;
            diag_q     <= diag_d;
            ack_drv_q  <= ack_drv_d;
            sda_oe_q   <= sda_oe_d;
            wr_cnt_q   <= wr_cnt_d;
            wr_pend_q  <= wr_pend_d;
            wr_val_q   <= wr_val_d;
            soft_dis_q <= soft_dis_d;
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    // open-drain pins only ever pull low
    assign TX_FAULT_O        = 1'b0;
    assign TX_FAULT_OE       = fault_oe_q;
    assign RX_SIGNAL_LOST_O  = 1'b0;
    assign RX_SIGNAL_LOST_OE = los_oe_q;
    assign SDA_O             = 1'b0;
    assign SDA_OE            = sda_oe_q;
    assign LASER_ENABLE      = laser_on_q;

endmodule : omcs_control

`default_nettype wire

// [omcs_control_bench.sv]
// testbench of the optical module control block
`timescale 1ns/10ps
`default_nettype none
`include "omcs_map.svh"
module omcs_control_bench;
    logic       clk, rst_n, tx_dis, flt, rx_ok;
    logic       scl, sda, sda_oe, f_oe, l_oe, las, a, x;
    logic       sda_o, f_o, l_o;
    logic [7:0] q;
    int         errors = 0;
    int         cmp_count = 0;
    int         cyc = 0;
    // open-drain data lines must stay low, so they sit in the compared zero bits
    wire logic [7:0] pins = {2'h0, sda_o, f_o, l_o, l_oe, f_oe, las};
    omcs_control #(.T_SERIAL_CYC(200), .T_DATA_CYC(4000), .T_WR_SHORT_CYC(600), .T_WR_LONG_CYC(1200)) omcs_control_i (
        .CLOCK(clk), .RST_N(rst_n), .TX_DISABLE(tx_dis), .TX_FAULT_O(f_o), .TX_FAULT_OE(f_oe),
        .RX_SIGNAL_LOST_O(l_o), .RX_SIGNAL_LOST_OE(l_oe), .SCL(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe),
        .LASER_FAULT(flt), .RX_SIGNAL_OK(rx_ok), .LASER_ENABLE(las));
    omcs_host omcs_host_i (.CLOCK(clk), .SDA_OE(sda_oe), .SCL(scl), .SDA(sda));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // the run needs some 13100 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            errors++;
            stop_test();
        end
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] v, input int n);
        omcs_host_i.start();
        omcs_host_i.byte_io({`OMCS_DIAG_SPACE, 1'b0}, q, a);
        omcs_host_i.byte_io(`OMCS_CSB_OFFSET, q, x);
        repeat (n) omcs_host_i.byte_io(v, q, x);
        omcs_host_i.stop();
    endtask : wr
    // data is only compared when the address is expected to be acked
    task automatic rd(input logic ea, input logic [7:0] e, input logic [6:0] d = `OMCS_DIAG_SPACE);
        omcs_host_i.start();
        omcs_host_i.byte_io({d, 1'b0}, q, a);
        omcs_host_i.byte_io(`OMCS_CSB_OFFSET, q, x);
        omcs_host_i.start();
        omcs_host_i.byte_io({d, 1'b1}, q, x);
        omcs_host_i.byte_io(8'hff, q, x);
        omcs_host_i.stop();
        chk({7'h0, a}, {7'h0, ea});
        if (ea) chk(q, e);
    endtask : rd
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    initial begin
        rst_n = 1'b0;
        tx_dis = 1'b0;
        flt = 1'b0;
        rx_ok = 1'b1;
        omcs_host_i.w(6);
        rst_n = 1'b1;
        rd(1'b0, 8'h00);
        rd(1'b1, 8'h01);
        tx_dis = 1'b1;
        omcs_host_i.w(4);
        chk(pins, 8'h06);
        rd(1'b1, 8'h81);
        tx_dis = 1'b0;
        omcs_host_i.w(3000);
        chk(pins, 8'h07);
        $display("pins done");
        flt = 1'b1;
        omcs_host_i.w(4);
        chk(pins, 8'h04);
        flt = 1'b0;
        rd(1'b1, 8'h04);
        tx_dis = 1'b1;
        omcs_host_i.w(50);
        tx_dis = 1'b0;
        omcs_host_i.w(4);
        chk(pins, 8'h04);
        tx_dis = 1'b1;
        omcs_host_i.w(210);
        tx_dis = 1'b0;
        omcs_host_i.w(4);
        chk(pins, 8'h07);
        $display("fault done");
        rx_ok = 1'b0;
        omcs_host_i.w(4);
        chk(pins, 8'h03);
        rd(1'b1, 8'h02);
        rx_ok = 1'b1;
        omcs_host_i.w(4);
        chk(pins, 8'h07);
        rd(1'b1, 8'h00);
        $display("loss done");
        wr(8'h40, 1);
        chk({a, pins[6:0]}, 8'h86);
        rd(1'b0, 8'h00);
        rd(1'b1, 8'h40);
        wr(8'h00, 5);
        omcs_host_i.w(300);
        rd(1'b0, 8'h00);
        omcs_host_i.w(100);
        rd(1'b1, 8'h00);
        chk(pins, 8'h07);
        rd(1'b1, 8'h00, `OMCS_ID_SPACE);
        $display("soft disable done");
        stop_test();
    end
endmodule : omcs_control_bench
`default_nettype wire

// [omcs_control_sva.sv]
// assertion checker for the optical module control block
`timescale 1ns/10ps
`default_nettype none
`include "omcs_map.svh"
module omcs_chk #(
    parameter int unsigned T_SERIAL_CYC = 200
) (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // pins
    input wire logic TX_DISABLE,
    input wire logic TX_FAULT_OE,
    input wire logic RX_SIGNAL_LOST_OE,
    input wire logic SDA_OE,
    input wire logic LASER_FAULT,
    input wire logic RX_SIGNAL_OK,
    input wire logic LASER_ENABLE
);
    logic [31:0] up_q, up_d;
    // saturates, so long power-on counts never wrap
    always_comb up_d = (&up_q) ? up_q : up_q + 32'h1;
    always_ff @(posedge CLOCK) up_q <= RST_N ? up_d : 32'h0;
    logic [7:0] hi_q;
    // length of the running disable pulse, saturating
    always_ff @(posedge CLOCK) hi_q <= (RST_N && TX_DISABLE) ? hi_q + {7'h0, !(&hi_q)} : 8'h00;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    a_dis_kill: assert property ($rose(TX_DISABLE) |-> ##[1:3] !LASER_ENABLE) else $error("laser on");
    a_pin_gate: assert property (LASER_ENABLE |-> !$past(TX_DISABLE, 3)) else $error("laser on");
    a_fault_pin: assert property ($rose(LASER_FAULT) |-> ##[1:3] !TX_FAULT_OE) else $error("no fault");
    a_fault_dark: assert property (!TX_FAULT_OE |-> !LASER_ENABLE) else $error("lit in fault");
    a_clr_pulse: assert property ($rose(TX_FAULT_OE) |-> $past(TX_DISABLE, 4) && !$past(TX_DISABLE, 3) &&
        $past(hi_q, 3) >= 8'(`OMCS_T_RESET_CYC)) else $error("bad clear");
    a_loss_set: assert property ($fell(RX_SIGNAL_OK) |-> ##[1:3] !RX_SIGNAL_LOST_OE) else $error("no loss");
    a_loss_clr: assert property ($rose(RX_SIGNAL_OK) |-> ##[1:3] RX_SIGNAL_LOST_OE) else $error("loss");
    a_bus_quiet: assert property (up_q < T_SERIAL_CYC |-> !SDA_OE) else $error("early ack");
    cover property ($fell(TX_FAULT_OE));
    cover property ($rose(TX_FAULT_OE));
    cover property ($rose(SDA_OE));
endmodule : omcs_chk
bind omcs_control omcs_chk #(.T_SERIAL_CYC(T_SERIAL_CYC)) omcs_chk_i (.CLOCK, .RST_N, .TX_DISABLE, .TX_FAULT_OE,
    .RX_SIGNAL_LOST_OE, .SDA_OE, .LASER_FAULT, .RX_SIGNAL_OK, .LASER_ENABLE);
`default_nettype wire

// [omcs_host.sv]
// host model of the two-wire management bus
`timescale 1ns/10ps
`default_nettype none
module omcs_host (
    // clock
    input  wire logic CLOCK,
    // two-wire bus
    input  wire logic SDA_OE,
    output var  logic SCL = 1'b1,
    output logic      SDA
);
    logic m_low = 1'b0;
    // pull-up: low while either side pulls
    assign SDA = !(m_low || SDA_OE);
    task automatic w(input int n);
        repeat (n) @(negedge CLOCK);
    endtask : w
    // scl low four cycles, so the ack lands before it rises
    task automatic bit_io(input logic b, output logic r);
        m_low = !b;
        w(2);
        SCL = 1'b1;
        w(4);
        r = SDA;
        SCL = 1'b0;
        w(2);
    endtask : bit_io
    task automatic start();
        m_low = 1'b0;
        w(2);
        SCL = 1'b1;
        w(4);
        m_low = 1'b1;
        w(2);
        SCL = 1'b0;
        w(2);
    endtask : start
    task automatic stop();
        m_low = 1'b1;
        w(2);
        SCL = 1'b1;
        w(4);
        m_low = 1'b0;
        w(400);
    endtask : stop
    task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic ack);
        logic n;
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(1'b1, n);
        ack = !n;
    endtask : byte_io
endmodule : omcs_host
`default_nettype wire

// [omcs_map.svh]
// address, field, reset and timing constants of the optical module control block
`ifndef OMCS_MAP_SVH
`define OMCS_MAP_SVH

// ----------------------------------------------------------------------------
// clock
// ----------------------------------------------------------------------------
`define OMCS_CLK_KHZ           20000

// ----------------------------------------------------------------------------
// two-wire address spaces and the control/status byte
// ----------------------------------------------------------------------------
`define OMCS_ID_SPACE          7'h50
`define OMCS_DIAG_SPACE        7'h51
`define OMCS_CSB_OFFSET        8'h6e
`define OMCS_SOFT_DIS_BIT      6
`define OMCS_SOFT_DIS_RESET    1'b0
`define OMCS_WR_SHORT_BYTES    4'h4
`define OMCS_WR_MAX_BYTES      4'h8

// ----------------------------------------------------------------------------
// times as printed, and their cycle counts
// ----------------------------------------------------------------------------
`define OMCS_T_RESET_US        10
`define OMCS_T_SERIAL_MS       300
`define OMCS_T_DATA_MS         1000
`define OMCS_T_WR_SHORT_MS     40
`define OMCS_T_WR_LONG_MS      80

// least time: round up
`define OMCS_T_RESET_CYC       ((`OMCS_T_RESET_US * `OMCS_CLK_KHZ + 999) / 1000)
// longest times: round down
`define OMCS_T_SERIAL_CYC      (`OMCS_T_SERIAL_MS * `OMCS_CLK_KHZ)
`define OMCS_T_DATA_CYC        (`OMCS_T_DATA_MS * `OMCS_CLK_KHZ)
`define OMCS_T_WR_SHORT_CYC    (`OMCS_T_WR_SHORT_MS * `OMCS_CLK_KHZ)
`define OMCS_T_WR_LONG_CYC     (`OMCS_T_WR_LONG_MS * `OMCS_CLK_KHZ)

`endif

// [omcs_pkg.sv]
// types shared by the optical module control block
package omcs_pkg;

    // ------------------------------------------------------------------------
    // control/status byte, msb first
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic       tx_dis_pin;
        logic       soft_dis;
        logic [2:0] rsvd;
        logic       fault;
        logic       sig_lost;
        logic       not_ready;
    } omcs_status_type;

    // ------------------------------------------------------------------------
    // pins that cross into the clock domain
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic scl;
        logic sda;
        logic tx_dis;
        logic laser_fault;
        logic rx_ok;
    } omcs_pins_type;

    // ------------------------------------------------------------------------
    // two-wire target states
    // ------------------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_IDLE  = 6'b000001,
        ST_ADDR  = 6'b000010,
        ST_ACK   = 6'b000100,
        ST_WBYTE = 6'b001000,
        ST_RBYTE = 6'b010000,
        ST_RACK  = 6'b100000
    } omcs_state_type;

endpackage : omcs_pkg

// [omcs_sync.sv]
// two flip-flop synchroniser bank with per-bit reset values
`timescale 1ns/10ps
`default_nettype none

module omcs_sync #(
    parameter int               WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // signals
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);

    if (WIDTH < 1) begin : g_bad_width
        $error("omcs_sync width must be at least one");
    end

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    // first stage feeds only the second
    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;

endmodule : omcs_sync

`default_nettype wire

// [omcs_timer.sv]
// loadable down-counting timer, running while the count is not zero
`timescale 1ns/10ps
`default_nettype none

module omcs_timer #(
    parameter int               WIDTH      = 25,
    parameter logic [WIDTH-1:0] RESET_LOAD = '0
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // control
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_value,
    // status
    output logic                  running
);

    if (WIDTH < 1) begin : g_bad_width
        $error("omcs_timer width must be at least one");
    end

    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;

    always_comb begin
        count_d = count_q;
        if (load) begin
            count_d = load_value;
        end else if (count_q != '0) begin
            count_d = count_q - 1'b1;
        end
    end

    // power-on timers start from reset itself
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_q <= RESET_LOAD;
        end else begin
            count_q <= count_d;
        end
    end

    assign running = (count_q != '0);

endmodule : omcs_timer

`default_nettype wire
